/* include/eeprom_pkg.sv */
// Shared constants and carrier types for the serial EEPROM command block.
// Assumes a single system clock (ref_clk) that samples every SPI pin.
package eeprom_pkg;

  // Command opcodes, eight bits each, shifted in most significant bit first.
  localparam logic [7:0] OP_PROGRAM_ENABLE  = 8'h06;
  localparam logic [7:0] OP_PROGRAM_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_READ     = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
  // Array commands: the upper nibble is zero and bit 3 carries address bit 8.
  localparam logic [3:0] OP_ARRAY_HI        = 4'h0;
  localparam logic [2:0] OP_ARRAY_READ_LO   = 3'h3;
  localparam logic [2:0] OP_ARRAY_WRITE_LO  = 3'h2;
  localparam int         OP_ADDR8_BIT       = 3;

  // Status byte layout.
  localparam int         ST_BUSY_BIT        = 0;
  localparam int         ST_WEL_BIT         = 1;
  localparam int         ST_PROT_LO_BIT     = 2;
  localparam int         ST_PROT_HI_BIT     = 3;
  localparam logic [3:0] ST_UPPER_VALUE     = 4'h0;

  // Reset values of the protection level and the write-enable latch.
  localparam logic [1:0] PROT_RESET         = 2'h0;
  localparam logic       WEL_RESET          = 1'b0;

  // Protected region starts for levels 1 and 2; level 3 guards everything.
  localparam logic [8:0] PROT_L1_START      = 9'h180;
  localparam logic [8:0] PROT_L2_START      = 9'h100;

  // Array geometry.
  localparam int         ADDR_W             = 9;
  localparam int         DATA_W             = 8;
  localparam int         PAGE_BYTES         = 4;

  // Self-timed program cycle, rounded up to whole clock cycles.
  localparam int         CLK_PERIOD_PS      = 5000;
  localparam int         PROG_TIME_NS       = 10000;
  localparam int         PROG_CYCLES        = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;

  // Pins coming from the SPI master; all asynchronous to ref_clk.
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } pin_in_s;

  // Idle pin levels: select high, clock low, protect counted as low until seen high.
  localparam pin_in_s PIN_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b0};

  // One byte committed to the storage array.
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } mem_wr_s;

endpackage

/* core/pin_sync.sv */
// Two-stage synchroniser for a group of asynchronous input pins.
// Assumes the inputs are independent levels; no bus coherency is implied.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage, so metastability settles there.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else if (clk_en) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

/* core/spi_eeprom_core.sv */
// Command engine of a 512-byte serial EEPROM slave on an SPI mode 0/3 link.
// Assumes every pin is asynchronous and SCK is well below a quarter of ref_clk.
`timescale 1ns/1ps
module spi_eeprom_core #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire eeprom_pkg::pin_in_s pin_i,
  output logic                     so_o,
  output logic                     so_oe,
  output eeprom_pkg::mem_wr_s      mem_wr,
  output logic [7:0]               status_o
);
  import eeprom_pkg::*;

  typedef enum logic [2:0] {
    FR_IDLE,
    FR_OPCODE,
    FR_ADDR,
    FR_DATA,
    FR_STAT_WR,
    FR_STAT_OUT,
    FR_IGNORE
  } frame_e;

  typedef enum logic [1:0] {
    PG_IDLE,
    PG_WAIT,
    PG_COMMIT
  } prog_e;

  pin_in_s                         pin_s;
  logic [$bits(pin_in_s)-1:0]      pin_flip;
  pin_in_s                         prev_q;
  frame_e                          frame_q;
  prog_e                           prog_q;
  logic [2:0]                      bit_cnt_q;
  logic [2:0]                      out_cnt_q;
  logic [7:0]                      shift_q;
  logic [7:0]                      out_sh_q;
  logic [ADDR_W-1:0]               addr_q;
  logic                            addr8_q;
  logic [PAGE_BYTES-1:0][DATA_W-1:0] page_q;
  logic [PAGE_BYTES-1:0]           page_vld_q;
  logic                            byte_seen_q;
  logic [1:0]                      pend_prot_q;
  logic                            wel_q;
  logic [1:0]                      prot_q;
  logic                            kind_status_q;
  logic [15:0]                     timer_q;
  logic [1:0]                      commit_idx_q;
  logic                            so_q;
  logic                            so_oe_q;
  mem_wr_s                         mem_wr_q;
  logic [7:0]                      status_q;

  logic                            sck_rise;
  logic                            sck_fall;
  logic                            cs_rise;
  logic                            busy;
  logic [7:0]                      shifted;
  logic                            byte_done;
  logic                            op_done;
  logic                            program_enable_cmd_ev;
  logic                            program_disable_cmd_ev;
  logic                            is_write_op;
  logic                            frame_ok;
  logic                            start_array;
  logic                            start_status;
  logic                            prog_done;
  logic [7:0]                      status_now;

  // Every pin passes two flip-flops before any logic looks at it. The pins are
  // flipped around their idle levels so that the zero reset of the synchroniser
  // reads as a deselected bus and no false select edge follows reset.
  pin_sync #(
    .WIDTH ($bits(pin_in_s))
  ) u_pin_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clk_en  (clk_en),
    .d       (pin_i ^ PIN_IDLE),
    .q       (pin_flip)
  );

  assign pin_s = pin_in_s'(pin_flip ^ PIN_IDLE);

  // A delayed copy of the synchronised pins gives their edges.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_q <= PIN_IDLE;
    end else if (clk_en) begin
      prev_q <= pin_s;
    end
  end

  // Clock edges only count while selected, which ignores bus traffic to other slaves.
  assign sck_rise  = pin_s.sck & ~prev_q.sck & ~pin_s.cs_n;
  assign sck_fall  = ~pin_s.sck & prev_q.sck & ~pin_s.cs_n;
  assign cs_rise   = pin_s.cs_n & ~prev_q.cs_n;
  assign busy      = (prog_q != PG_IDLE);
  assign shifted   = {shift_q[6:0], pin_s.si};
  assign byte_done = sck_rise && (bit_cnt_q == 3'h7);
  assign op_done   = byte_done && (frame_q == FR_OPCODE);

  // Opcode decode; an array write carries address bit 8 inside the opcode.
  assign is_write_op = (shifted[7:4] == OP_ARRAY_HI)
                     && (shifted[2:0] == OP_ARRAY_WRITE_LO);
  assign program_enable_cmd_ev     = op_done && !busy && (shifted == OP_PROGRAM_ENABLE);
  assign program_disable_cmd_ev     = op_done && !busy && (shifted == OP_PROGRAM_DISABLE);

  // A write counts only if select rose on a byte boundary after at least one byte.
  assign frame_ok     = cs_rise && byte_seen_q && (bit_cnt_q == 3'h0);
  assign start_array  = frame_ok && (frame_q == FR_DATA) && prev_q.wp_n && wel_q
                      && !is_protected(prot_q, addr_q);
  assign start_status = frame_ok && (frame_q == FR_STAT_WR) && prev_q.wp_n && wel_q;

  // End of a program cycle, seen in the same cycle that busy drops, so the
  // latch and busy clear together and no poll ever sees ready with the latch set.
  assign prog_done = ((prog_q == PG_WAIT) && (timer_q == 16'h0000) && kind_status_q)
                   || ((prog_q == PG_COMMIT) && (commit_idx_q == 2'h3));

  // Live status byte with the reserved upper nibble read as zero.
  assign status_now = {ST_UPPER_VALUE, prot_q, wel_q, busy};

  // Protected address test for the current block protection level.
  function automatic logic is_protected(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
    logic res;
    res = 1'b0;
    case (lvl)
      2'h0:    res = 1'b0;
      2'h1:    res = (a >= PROT_L1_START);
      2'h2:    res = (a >= PROT_L2_START);
      default: res = 1'b1;
    endcase
    return res;
  endfunction

  // Frame sequencer: tracks the command being received while selected.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_q <= FR_IDLE;
    end else if (clk_en) begin
      if (pin_s.cs_n) begin
        frame_q <= FR_IDLE;
      end else begin
        case (frame_q)
          FR_IDLE: begin
            frame_q <= FR_OPCODE;
          end
          FR_OPCODE: begin
            if (op_done) begin
              if (busy && (shifted != OP_STATUS_READ)) begin
                frame_q <= FR_IGNORE;
              end else if (shifted == OP_STATUS_READ) begin
                frame_q <= FR_STAT_OUT;
              end else if (shifted == OP_STATUS_WRITE) begin
                frame_q <= FR_STAT_WR;
              end else if (is_write_op) begin
                frame_q <= FR_ADDR;
              end else begin
                frame_q <= FR_IGNORE;
              end
            end
          end
          FR_ADDR: begin
            if (byte_done) begin
              frame_q <= FR_DATA;
            end
          end
          FR_DATA, FR_STAT_WR, FR_STAT_OUT, FR_IGNORE: begin
            frame_q <= frame_q;
          end
          default: begin
            frame_q <= FR_IDLE;
          end
        endcase
      end
    end
  end

  // Input shifter and bit counter run on every rising SCK of a frame, except in status output and ignored frames.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_q   <= 8'h00;
      bit_cnt_q <= 3'h0;
    end else if (clk_en) begin
      if (frame_q == FR_IDLE) begin
        bit_cnt_q <= 3'h0;
      end else if (sck_rise && (frame_q != FR_STAT_OUT) && (frame_q != FR_IGNORE)) begin
        shift_q   <= shifted;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
    end
  end

  // Address and page buffer; frozen while a cycle runs since writes are refused then.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr8_q     <= 1'b0;
      addr_q      <= '0;
      page_q      <= '0;
      page_vld_q  <= '0;
      byte_seen_q <= 1'b0;
      pend_prot_q <= PROT_RESET;
    end else if (clk_en) begin
      if (frame_q == FR_IDLE) begin
        byte_seen_q <= 1'b0;
      end
      if (op_done && !busy && is_write_op) begin
        addr8_q    <= shifted[OP_ADDR8_BIT];
        page_vld_q <= '0;
      end
      if (byte_done && (frame_q == FR_ADDR)) begin
        addr_q <= {addr8_q, shifted};
      end
      if (byte_done && (frame_q == FR_DATA)) begin
        page_q[addr_q[1:0]]     <= shifted;
        page_vld_q[addr_q[1:0]] <= 1'b1;
        addr_q[1:0]             <= addr_q[1:0] + 2'h1;
        byte_seen_q             <= 1'b1;
      end
      if (byte_done && (frame_q == FR_STAT_WR)) begin
        pend_prot_q <= shifted[ST_PROT_HI_BIT:ST_PROT_LO_BIT];
        byte_seen_q <= 1'b1;
      end
    end
  end

  // Write-enable latch; the completion clear cannot meet an enable because
  // enables are refused while busy.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wel_q <= WEL_RESET;
    end else if (clk_en) begin
      if (prog_done) begin
        wel_q <= 1'b0;
      end else if (program_enable_cmd_ev) begin
        wel_q <= 1'b1;
      end else if (program_disable_cmd_ev) begin
        wel_q <= 1'b0;
      end
    end
  end

  // Program cycle sequencer: once started it ignores the protect pin.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prog_q        <= PG_IDLE;
      timer_q       <= 16'h0000;
      kind_status_q <= 1'b0;
      commit_idx_q  <= 2'h0;
      prot_q        <= PROT_RESET;
      mem_wr_q      <= '0;
    end else if (clk_en) begin
      mem_wr_q.we <= 1'b0;
      case (prog_q)
        PG_IDLE: begin
          if (start_array || start_status) begin
            prog_q        <= PG_WAIT;
            timer_q       <= 16'(PROG_CYCLES - 1);
            kind_status_q <= start_status;
          end
        end
        PG_WAIT: begin
          if (timer_q == 16'h0000) begin
            if (kind_status_q) begin
              prot_q    <= pend_prot_q;
              prog_q    <= PG_IDLE;
            end else begin
              commit_idx_q <= 2'h0;
              prog_q       <= PG_COMMIT;
            end
          end else begin
            timer_q <= timer_q - 16'h0001;
          end
        end
        PG_COMMIT: begin
          mem_wr_q.we   <= page_vld_q[commit_idx_q];
          mem_wr_q.addr <= {addr_q[ADDR_W-1:2], commit_idx_q};
          mem_wr_q.data <= page_q[commit_idx_q];
          commit_idx_q  <= commit_idx_q + 2'h1;
          if (commit_idx_q == 2'h3) begin
            prog_q    <= PG_IDLE;
          end
        end
        default: begin
          prog_q <= PG_IDLE;
        end
      endcase
    end
  end

  // Serial output: the status byte repeats while clocks keep coming.
  // Busy is sampled fresh at each byte start so polling sees it drop.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      so_q      <= 1'b0;
      so_oe_q   <= 1'b0;
      out_sh_q  <= 8'h00;
      out_cnt_q <= 3'h0;
    end else if (clk_en) begin
      if (frame_q != FR_STAT_OUT) begin
        so_oe_q   <= 1'b0;
        out_cnt_q <= 3'h0;
        out_sh_q  <= status_now;
      end else if (sck_fall) begin
        so_oe_q   <= 1'b1;
        out_cnt_q <= out_cnt_q + 3'h1;
        if (out_cnt_q == 3'h0) begin
          so_q     <= status_now[7];
          out_sh_q <= {status_now[6:0], 1'b0};
        end else begin
          so_q     <= out_sh_q[7];
          out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
      end
    end
  end

  // Status mirror for the user side.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_q <= {ST_UPPER_VALUE, PROT_RESET, WEL_RESET, 1'b0};
    end else if (clk_en) begin
      status_q <= status_now;
    end
  end

  assign so_o     = so_q;
  assign so_oe    = so_oe_q;
  assign mem_wr   = mem_wr_q;
  assign status_o = status_q;

endmodule

/* verification/spi_eeprom_core_sva.sv */
// Port assertions for the EEPROM command engine.
// Assumes status_o lags internal state by one cycle.
`timescale 1ns/1ps
module spi_eeprom_core_sva #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                clk_en,
  input wire eeprom_pkg::pin_in_s pin_i,
  input wire logic                so_o,
  input wire logic                so_oe,
  input wire eeprom_pkg::mem_wr_s mem_wr,
  input wire logic [7:0]          status_o
);
  import eeprom_pkg::*;
  int busy_cnt_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Busy run length, so that a cut-short program cycle shows up.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= status_o[ST_BUSY_BIT] ? busy_cnt_q + 1 : 0;
    end
  end

  AST_UPPER_ZERO: assert property (status_o[7:4] == ST_UPPER_VALUE)
    else $error("status upper nibble not zero");
  AST_SO_IDLE: assert property (pin_i.cs_n [*8] |-> !so_oe)
    else $error("SO driven while deselected");
  AST_COMMIT_BUSY: assert property (mem_wr.we |-> status_o[ST_BUSY_BIT] && status_o[ST_WEL_BIT])
    else $error("commit outside an enabled program cycle");
  AST_WEL_AFTER: assert property ($fell(status_o[ST_BUSY_BIT]) |-> !status_o[ST_WEL_BIT])
    else $error("enable latch kept after program cycle");
  AST_START_WEL: assert property ($rose(status_o[ST_BUSY_BIT]) |-> status_o[ST_WEL_BIT])
    else $error("program cycle without enable latch");
  AST_START_CS: assert property ($rose(status_o[ST_BUSY_BIT]) |-> pin_i.cs_n && $past(pin_i.cs_n, 2))
    else $error("program cycle started while selected");
  AST_START_WP: assert property ($rose(status_o[ST_BUSY_BIT]) |-> $past(pin_i.wp_n, 2))
    else $error("program cycle started with protect pin low");
  AST_PROT_END: assert property ($changed(status_o[3:2]) |-> $fell(status_o[ST_BUSY_BIT]))
    else $error("protect level changed outside a status write end");
  AST_PROG_LEN: assert property ($fell(status_o[ST_BUSY_BIT]) |-> busy_cnt_q >= PROG_CYCLES)
    else $error("program cycle too short");
  AST_PAGE_UPPER: assert property (mem_wr.we && $past(mem_wr.we) |-> mem_wr.addr[8:2] == $past(mem_wr.addr[8:2]))
    else $error("page commit crossed a page");

  CV_COMMIT: cover property (mem_wr.we);
  CV_SO_ON: cover property ($rose(so_oe));
  CV_PROT: cover property ($changed(status_o[3:2]));
endmodule

/* verification/spi_master_model.sv */
// Mode 0 SPI master model; SCK rests low between frames.
// Assumes the bench owns the protect pin and resolves SO with a pull-up.
`timescale 1ns/1ps
module spi_master_model (
  input  wire logic ref_clk,
  input  wire logic so_line,
  output logic      cs_n,
  output logic      sck,
  output logic      si
);
  // Idle levels at time zero.
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // One frame, MSB first, 125 ns SCK; SI is inverted after release so stale data never helps.
  task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = '0;
    @(negedge ref_clk);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si = tx[i];
      repeat (13) @(negedge ref_clk);
      sck = 1'b1;
      rx = {rx[62:0], so_line};
      repeat (12) @(negedge ref_clk);
      sck = 1'b0;
    end
    repeat (6) @(negedge ref_clk);
    cs_n = 1'b1;
    si   = ~si;
    repeat (12) @(negedge ref_clk);
  endtask
endmodule

/* verification/spi_eeprom_status_and_write_control_tb.sv */
// Self-checking bench for the EEPROM command engine behind its SPI pins.
// Assumes the master model owns cs_n, sck and si; SO has a pull-up.
`timescale 1ns/1ps
module spi_eeprom_status_and_write_control_tb;
  import eeprom_pkg::*;
  localparam int PROG = 600;
  logic        ref_clk;
  logic        rst;
  logic        clk_en;
  logic        wp_n;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        so_o;
  logic        so_oe;
  logic        so_line;
  logic [7:0]  status_o;
  logic [7:0]  s;
  logic [63:0] rx;
  logic [16:0] wq[$];
  logic [1:0]  prot;
  logic        wel;
  pin_in_s     pin_i;
  mem_wr_s     mem_wr;
  int          seed;
  int          miscompares;
  int          cmp_count;

  assign pin_i   = {cs_n, sck, si, wp_n};
  assign so_line = so_oe ? so_o : 1'b1;

  spi_eeprom_core #(
    .PROG_CYCLES (PROG)
  ) uut (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .pin_i    (pin_i),
    .so_o     (so_o),
    .so_oe    (so_oe),
    .mem_wr   (mem_wr),
    .status_o (status_o)
  );
  spi_master_model m (.ref_clk(ref_clk), .so_line(so_line), .cs_n(cs_n), .sck(sck), .si(si));

  // 200 MHz reference clock.
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Every committed byte is queued for comparison.
  always @(posedge ref_clk) begin
    if (mem_wr.we === 1'b1) wq.push_back({mem_wr.addr, mem_wr.data});
  end

  function automatic logic prot_hit(input logic [1:0] lvl, input logic [8:0] a);
    return (lvl == 2'h3) || (lvl == 2'h2 && a >= 9'h100) || (lvl == 2'h1 && a >= 9'h180);
  endfunction

  function automatic logic [7:0] exp_st();
    return {4'h0, prot, wel, 1'b0};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic status_read_cmd(output logic [7:0] st);
    logic [63:0] r;
    m.frame(16, {48'h0, OP_STATUS_READ, 8'($random(seed))}, r);
    st = r[7:0];
  endtask

  // Only status reads while busy; a bounded poll.
  task automatic poll();
    logic [7:0] st;
    for (int i = 0; i < 20; i++) begin
      status_read_cmd(st);
      if (st[0] === 1'b0) return;
    end
    miscompares++;
    end_of_test();
  endtask

  task automatic enable(input logic en);
    logic [63:0] r;
    if (en) begin
      m.frame(8, {56'h0, OP_PROGRAM_ENABLE}, r);
      wel = 1'b1;
    end
  endtask

  task automatic do_write(input logic [8:0] a, input int n, input logic [47:0] d, input logic en);
    logic [63:0] tx;
    logic [63:0] r;
    logic [7:0]  pg[4];
    logic [3:0]  ld;
    logic [7:0]  st;
    logic        ok;
    tx = {48'h0, OP_ARRAY_HI, a[8], OP_ARRAY_WRITE_LO, a[7:0]};
    ld = 4'h0;
    enable(en);
    for (int i = 0; i < n; i++) begin
      tx = {tx[55:0], d[8*(n-1-i) +: 8]};
      pg[2'(a[1:0] + i)] = d[8*(n-1-i) +: 8];
      ld[2'(a[1:0] + i)] = 1'b1;
    end
    ok = wel && wp_n && !prot_hit(prot, a);
    m.frame(16 + 8 * n, tx, r);
    status_read_cmd(st);
    check(32'(st[0]), 32'(ok));
    poll();
    for (int k = 0; k < 4; k++) begin
      if (ok && ld[k]) begin
        check(32'(wq.size() > 0 ? wq.pop_front() : {17{1'bx}}), 32'({a[8:2], 2'(k), pg[k]}));
      end
    end
    check(32'(wq.size()), 32'h0);
    wel = wel && !ok;
    status_read_cmd(st);
    check(32'(st), 32'(exp_st()));
  endtask

  task automatic do_status_write_cmd(input logic [7:0] d, input logic en);
    logic [63:0] r;
    logic [7:0]  st;
    logic        ok;
    enable(en);
    ok = wel && wp_n;
    m.frame(16, {48'h0, OP_STATUS_WRITE, d}, r);
    poll();
    if (ok) prot = d[3:2];
    wel = wel && !ok;
    status_read_cmd(st);
    check(32'(st), 32'(exp_st()));
  endtask

  // Main sequence: reset, control opcodes, protection sweep, page wrap, refusals.
  initial begin
    seed = 4587;
    rst = 1'b1;
    clk_en = 1'b1;
    wp_n = 1'b1;
    prot = 2'h0;
    wel = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(32'(status_o), 32'h0);
    status_read_cmd(s);
    check(32'(s), 32'h0);
    do_write(9'h010, 1, 48'h5A, 1'b0);
    enable(1'b1);
    status_read_cmd(s);
    check(32'(s), 32'h02);
    // A disable sent while the block is frozen must go unseen.
    clk_en = 1'b0;
    m.frame(8, {56'h0, OP_PROGRAM_DISABLE}, rx);
    clk_en = 1'b1;
    status_read_cmd(s);
    check(32'(s), 32'h02);
    m.frame(8, {56'h0, OP_PROGRAM_DISABLE}, rx);
    wel = 1'b0;
    status_read_cmd(s);
    check(32'(s), 32'h00);
    do_write(9'h020, 1, 48'hC3, 1'b0);
    m.frame(16, {48'h0, 8'hFF, 8'h00}, rx);
    check(32'(rx[7:0]), 32'hFF);
    for (int lvl = 0; lvl < 4; lvl++) begin
      do_status_write_cmd({4'($random(seed)), 2'(lvl), 2'($random(seed))}, 1'b1);
      do_write(9'($random(seed)), 1, 48'($random(seed)), 1'b1);
      do_write(lvl == 1 ? 9'h180 : (lvl == 2 ? 9'h0FF : 9'h17F), 2, 48'($random(seed)), 1'b1);
    end
    do_status_write_cmd(8'h00, 1'b1);
    do_write(9'h0A6, 6, 48'h112233445566, 1'b1);
    do_status_write_cmd(8'h0C, 1'b0);
    wp_n = 1'b0;
    do_write(9'h010, 1, 48'hA5, 1'b1);
    do_status_write_cmd(8'h08, 1'b1);
    wp_n = 1'b1;
    end_of_test();
  end
endmodule

bind spi_eeprom_core spi_eeprom_core_sva #(.PROG_CYCLES(PROG_CYCLES)) sva (
  .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .pin_i(pin_i), .so_o(so_o),
  .so_oe(so_oe), .mem_wr(mem_wr), .status_o(status_o));
